// >>> aac_pkg.sv
// Constants, types and register map for the auto answer call controller.
// Assumes a 100 MHz system clock and an APB master with 32-bit data.
package aac_pkg;
   localparam int CLK_PERIOD_NS  = 10;
   localparam int TICK_PERIOD_NS = 1000000;
   localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TMR_W          = 14;

   localparam logic [TMR_W-1:0] CARRIER_WAIT_MS = 14'h2800;
   localparam logic [TMR_W-1:0] LONG_SPACE_MS   = 14'h0500;
   localparam logic [TMR_W-1:0] CARRIER_LOSS_MS = 14'h0032;
   localparam logic [TMR_W-1:0] DLY_10240_MS    = 14'h2800;
   localparam logic [TMR_W-1:0] DLY_5120_MS     = 14'h1400;
   localparam logic [TMR_W-1:0] DLY_2560_MS     = 14'h0A00;
   localparam logic [TMR_W-1:0] DLY_1280_MS     = 14'h0500;
   localparam logic [TMR_W-1:0] DLY_640_MS      = 14'h0280;
   localparam logic [TMR_W-1:0] DLY_320_MS      = 14'h0140;
   localparam logic [TMR_W-1:0] DLY_160_MS      = 14'h00A0;
   localparam logic [TMR_W-1:0] DLY_80_MS       = 14'h0050;
   localparam logic [TMR_W-1:0] DLY_MIN_MS      = 14'h0002;

   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_CAUSE  = 8'h08;
   localparam logic [7:0] CTRL_RESET  = 8'h3E;

   typedef struct packed {
      logic [3:0] delay_sel;
      logic       abm_en;
      logic       long_space_en;
      logic       eot_en;
      logic       online;
   } aac_ctrl_s;

   typedef struct packed {
      logic long_space;
      logic eot;
      logic carrier_lost;
      logic no_carrier;
   } aac_cause_s;

   typedef enum logic [3:0] {
      idle_state      = 4'h1,
      answering_state = 4'h2,
      delay_state     = 4'h4,
      connected_state = 4'h8
   } aac_state_e;
endpackage : aac_pkg

// >>> aac_top.sv
// Auto answer call controller with APB register access.
// Assumes modem pins are asynchronous; end_char_received is on clk.
`timescale 1ns/1ps
module aac_top #(
   parameter int TICK_CYC = aac_pkg::TICK_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        set_ready_in,
   input  wire logic        carrier_present_in,
   input  wire logic        ring_in,
   input  wire logic        line_data_mark,
   input  wire logic        path_cut_through_in,
   input  wire logic        end_char_received,
   output logic             answer_line_out,
   output logic             off_hook_out,
   output logic             line_busy_out,
   output logic             answerback_store,
   output logic             blind_out,
   output logic             ring_lamp,
   output logic             term_ready_lamp,
   output logic             line_ready_lamp
);
   import aac_pkg::*;

   localparam int TCW = $clog2(TICK_CYC + 1);

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   logic [4:0] raw;
   logic [4:0] s1_r;
   logic [4:0] s2_r;
   logic [4:0] s3_r;
   logic [4:0] flt_r;
   assign raw = {path_cut_through_in, line_data_mark, ring_in,
                 carrier_present_in, set_ready_in};

   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_sync
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               s1_r[gi]  <= 1'b0;
               s2_r[gi]  <= 1'b0;
               s3_r[gi]  <= 1'b0;
               flt_r[gi] <= 1'b0;
            end else begin
               s1_r[gi] <= raw[gi];
               s2_r[gi] <= s1_r[gi];
               s3_r[gi] <= s2_r[gi];
               if (s2_r[gi] == s3_r[gi]) begin
                  flt_r[gi] <= s3_r[gi];
               end
            end
         end
      end
   endgenerate

   logic dsr;
   logic dcd;
   logic ring;
   logic mark;
   logic cut_thru;
   assign dsr      = flt_r[0];
   assign dcd      = flt_r[1];
   assign ring     = flt_r[2];
   assign mark     = flt_r[3];
   assign cut_thru = flt_r[4];

   ////////////////////////////////////////////////////////////////////////
   // Millisecond tick
   logic [TCW-1:0] tick_cnt_r;
   logic           tick_r;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tick_cnt_r <= '0;
         tick_r     <= 1'b0;
      end else if (tick_cnt_r == TCW'(TICK_CYC - 1)) begin
         tick_cnt_r <= '0;
         tick_r     <= 1'b1;
      end else begin
         tick_cnt_r <= tick_cnt_r + 1'b1;
         tick_r     <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers and helpers
   aac_ctrl_s  ctrl_r;
   aac_cause_s cause_r;
   aac_cause_s cause_set;
   aac_state_e state_r;
   aac_state_e state_nxt;
   logic [TMR_W-1:0] tmr_r;
   logic [TMR_W-1:0] loss_r;
   logic dtr_r;
   logic dtr_nxt;

   function automatic logic [TMR_W-1:0] delay_ms(input logic [3:0] sel);
      case (sel)
         4'h0:    delay_ms = DLY_10240_MS;
         4'h1:    delay_ms = DLY_5120_MS;
         4'h2:    delay_ms = DLY_2560_MS;
         4'h3:    delay_ms = DLY_1280_MS;
         4'h4:    delay_ms = DLY_640_MS;
         4'h5:    delay_ms = DLY_320_MS;
         4'h6:    delay_ms = DLY_160_MS;
         4'h7:    delay_ms = DLY_80_MS;
         default: delay_ms = DLY_MIN_MS;
      endcase
   endfunction : delay_ms

   logic wait_to;
   logic dly_done;
   logic ls_to;
   logic carrier_lost;
   logic eot_hit;
   logic in_call;
   logic hang;
   assign wait_to      = (tmr_r >= CARRIER_WAIT_MS);
   assign dly_done     = (tmr_r >= delay_ms(ctrl_r.delay_sel));
   assign ls_to        = ctrl_r.long_space_en & (tmr_r >= LONG_SPACE_MS);
   assign carrier_lost = (loss_r >= CARRIER_LOSS_MS);
   assign eot_hit      = ctrl_r.eot_en & end_char_received;
   assign in_call      = (state_r != idle_state);
   assign hang         = in_call & (state_nxt == idle_state);

   ////////////////////////////////////////////////////////////////////////
   // Call state machine
   always_comb begin
      state_nxt = idle_state;
      case (state_r)
         idle_state: begin
            if (dtr_r & dsr) begin
               state_nxt = answering_state;
            end
         end
         answering_state: begin
            if (dcd) begin
               state_nxt = delay_state;
            end else if (!wait_to) begin
               state_nxt = answering_state;
            end
         end
         delay_state: begin
            state_nxt = dly_done ? connected_state : delay_state;
         end
         connected_state: begin
            if (!eot_hit & !carrier_lost & !ls_to) begin
               state_nxt = connected_state;
            end
         end
         default: state_nxt = idle_state;
      endcase
      if (!ctrl_r.online) begin
         state_nxt = idle_state;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= idle_state;
      end else begin
         state_r <= state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Shared delay timer and carrier loss timer
   logic tmr_clr;
   logic tmr_run;
   assign tmr_clr = (state_r == idle_state)
                  | ((state_r == answering_state) & dcd)
                  | ((state_r == delay_state) & dly_done)
                  | ((state_r == connected_state) & mark);
   assign tmr_run = ((state_r == answering_state) & !dcd)
                  | (state_r == delay_state)
                  | ((state_r == connected_state) & !mark);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tmr_r <= '0;
      end else if (tmr_clr) begin
         tmr_r <= '0;
      end else if (tick_r & tmr_run & (tmr_r != '1)) begin
         tmr_r <= tmr_r + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         loss_r <= '0;
      end else if (dcd | (state_r != connected_state)) begin
         loss_r <= '0;
      end else if (tick_r & !carrier_lost) begin
         loss_r <= loss_r + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Answer line and off-hook
   assign dtr_nxt = ctrl_r.online & (ring | (dtr_r & !hang));

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dtr_r        <= 1'b0;
         off_hook_out <= 1'b0;
      end else begin
         dtr_r        <= dtr_nxt;
         off_hook_out <= dtr_nxt;
      end
   end
   assign answer_line_out = dtr_r;

   ////////////////////////////////////////////////////////////////////////
   // Lamps, busy and answer-back trigger
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         line_busy_out    <= 1'b1;
         line_ready_lamp  <= 1'b0;
         term_ready_lamp  <= 1'b0;
         ring_lamp        <= 1'b0;
         answerback_store <= 1'b0;
      end else begin
         line_busy_out    <= (state_nxt != connected_state);
         line_ready_lamp  <= (state_nxt == connected_state);
         term_ready_lamp  <= ctrl_r.online;
         ring_lamp        <= (state_nxt == answering_state)
                           | ((state_nxt == idle_state) & ring);
         answerback_store <= ctrl_r.abm_en & (state_r == delay_state)
                           & (state_nxt == connected_state);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Hang-up cause and blinding
   always_comb begin
      cause_set.no_carrier   = (state_r == answering_state) & !dcd & wait_to;
      cause_set.carrier_lost = (state_r == connected_state) & carrier_lost;
      cause_set.eot          = (state_r == connected_state) & eot_hit;
      cause_set.long_space   = (state_r == connected_state) & ls_to;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         blind_out <= 1'b0;
      end else if (hang & (|cause_set)) begin
         blind_out <= 1'b1;
      end else if ((state_r == idle_state) & (state_nxt == answering_state)) begin
         blind_out <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB slave
   logic acc_ok;
   logic [31:0] status_w;
   assign acc_ok = psel & penable & pready & !pslverr;
   assign status_w = {20'h00000, cut_thru, blind_out, dtr_r, line_busy_out,
                      dcd, dsr, ring, mark, state_r};

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else if (psel & !penable) begin
         pready  <= 1'b1;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
         case (paddr)
            ADDR_CTRL:   prdata <= {24'h000000, ctrl_r};
            ADDR_STATUS: prdata <= status_w;
            ADDR_CAUSE:  prdata <= {28'h0000000, cause_r};
            default:     pslverr <= 1'b1;
         endcase
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_r <= CTRL_RESET;
      end else if (acc_ok & pwrite & (paddr == ADDR_CTRL)) begin
         ctrl_r <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cause_r <= '0;
      end else if (acc_ok & pwrite & (paddr == ADDR_CAUSE)) begin
         cause_r <= (cause_r & ~pwdata[3:0]) | cause_set;
      end else begin
         cause_r <= cause_r | cause_set;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   property p_abm_fire;
      @(posedge clk) disable iff (!arst_n)
      answerback_store |-> state_r == connected_state && $past(state_r) == delay_state;
   endproperty
   a_abm_fire: assert property (p_abm_fire) else $error("answer-back fired out of step");

   property p_busy;
      @(posedge clk) disable iff (!arst_n)
      line_busy_out == (state_r != connected_state);
   endproperty
   a_busy: assert property (p_busy) else $error("line busy wrong");

   property p_ready_lamp;
      @(posedge clk) disable iff (!arst_n)
      line_ready_lamp |-> state_r == connected_state && !line_busy_out;
   endproperty
   a_ready_lamp: assert property (p_ready_lamp) else $error("line ready without call");

   property p_wait_to;
      @(posedge clk) disable iff (!arst_n)
      state_r == answering_state && !dcd && tmr_r >= CARRIER_WAIT_MS
      |=> state_r == idle_state && !answer_line_out;
   endproperty
   a_wait_to: assert property (p_wait_to) else $error("no carrier timeout missed");

   property p_eot;
      @(posedge clk) disable iff (!arst_n)
      state_r == connected_state && eot_hit |=> !answer_line_out && blind_out ##1 !line_ready_lamp;
   endproperty
   a_eot: assert property (p_eot) else $error("end character did not hang up");

   property p_loss;
      @(posedge clk) disable iff (!arst_n)
      state_r == connected_state && loss_r >= CARRIER_LOSS_MS |=> state_r == idle_state;
   endproperty
   a_loss: assert property (p_loss) else $error("carrier loss missed");

   property p_mark_clr;
      @(posedge clk) disable iff (!arst_n)
      state_r == connected_state && mark |=> tmr_r == '0;
   endproperty
   a_mark_clr: assert property (p_mark_clr) else $error("mark did not clear timer");

   property p_dly;
      @(posedge clk) disable iff (!arst_n)
      state_r == delay_state && dly_done |=> state_r == connected_state || !ctrl_r.online;
   endproperty
   a_dly: assert property (p_dly) else $error("delay expiry ignored");

   property p_tick;
      @(posedge clk) disable iff (!arst_n)
      tick_r |-> tick_cnt_r == '0 ##1 !tick_r;
   endproperty
   a_tick: assert property (p_tick) else $error("tick too frequent");

   c_connect: cover property (@(posedge clk) disable iff (!arst_n) answerback_store);
   c_eot: cover property (@(posedge clk) disable iff (!arst_n)
      state_r == connected_state && eot_hit);
   c_no_carrier: cover property (@(posedge clk) disable iff (!arst_n) cause_set.no_carrier);
endmodule : aac_top

// >>> aac_modem_model.sv
// Far-side modem model for the auto answer bench.
// Assumes the bench drives ring, carrier and space requests at clk edges.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module aac_modem_model (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic off_hook_out,
   input  wire logic ring_req,
   input  wire logic carrier_req,
   input  wire logic space_req,
   output logic      ring_in,
   output logic      set_ready_in,
   output logic      carrier_present_in,
   output logic      line_data_mark,
   output logic      path_cut_through_in
);
   ////////////////////////////////////////////////////////////
   // Ring follows its request one clk later; carrier follows once the line is held, space once carrier is present
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ring_in             <= 1'b0;
         set_ready_in        <= 1'b0;
         path_cut_through_in <= 1'b0;
         carrier_present_in  <= 1'b0;
         line_data_mark      <= 1'b1;
      end else begin
         ring_in             <= ring_req;
         set_ready_in        <= off_hook_out;
         path_cut_through_in <= off_hook_out;
         carrier_present_in  <= carrier_req & path_cut_through_in;
         line_data_mark      <= ~(space_req & carrier_present_in);
      end
   end
endmodule : aac_modem_model

// >>> aac_testbench.sv
// Self-checking bench for the auto answer call controller.
// Assumes aac_pkg, aac_top and aac_modem_model; tick shortened to 2 clk.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
   $display("mismatch t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
////////////////////////////////////////////////////////////
module testbench;
   import aac_pkg::*;
   localparam int TK = 2;
   logic        clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rq;
   logic        pready, pslverr, re, set_ready_in, carrier_present_in, ring_in;
   logic        line_data_mark, path_cut_through_in, answer_line_out, off_hook_out;
   logic        line_busy_out, answerback_store, blind_out, ring_lamp, term_ready_lamp, line_ready_lamp;
   logic        end_char_received = 1'b0, ring_req = 1'b0, carrier_req = 1'b0, space_req = 1'b0;
   int          fails = 0, tests_run = 0, cyc = 0, n;
   int          dly [9] = '{10240, 5120, 2560, 1280, 640, 320, 160, 80, 2};

   aac_top #(.TICK_CYC(TK)) dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .set_ready_in(set_ready_in), .carrier_present_in(carrier_present_in),
      .ring_in(ring_in), .line_data_mark(line_data_mark), .path_cut_through_in(path_cut_through_in),
      .end_char_received(end_char_received), .answer_line_out(answer_line_out),
      .off_hook_out(off_hook_out), .line_busy_out(line_busy_out), .answerback_store(answerback_store),
      .blind_out(blind_out), .ring_lamp(ring_lamp), .term_ready_lamp(term_ready_lamp),
      .line_ready_lamp(line_ready_lamp));

   aac_modem_model u_far (.clk(clk), .arst_n(arst_n), .off_hook_out(off_hook_out),
      .ring_req(ring_req), .carrier_req(carrier_req), .space_req(space_req), .ring_in(ring_in),
      .set_ready_in(set_ready_in), .carrier_present_in(carrier_present_in),
      .line_data_mark(line_data_mark), .path_cut_through_in(path_cut_through_in));

   ////////////////////////////////////////////////////////////
   // Clock and hang guard
   always #5 clk = ~clk;

   always @(posedge clk) begin
      cyc++;
      if (cyc == 90000) begin
         fails++;
         stop_test();
      end
   end

   task automatic stop_test;
      $display("compares %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : stop_test

   ////////////////////////////////////////////////////////////
   // APB master, entered just after a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rq = prdata;
      re = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic wt(input int c);
      repeat (c) @(posedge clk);
   endtask : wt

   task automatic st(input logic [3:0] s);
      apb(1'b0, ADDR_STATUS, 32'h0);
      `CHK(rq[3:0], s);
   endtask : st

   function automatic logic sig(input int w);
      case (w)
         0:       return answer_line_out;
         1:       return answerback_store;
         default: return line_ready_lamp;
      endcase
   endfunction : sig

   task automatic cnt(input int w, input logic v, input int lim);
      n = 0;
      while (sig(w) !== v && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask : cnt

   ////////////////////////////////////////////////////////////
   // Call phases
   task automatic call(input logic [3:0] sel);
      apb(1'b1, ADDR_CTRL, {24'h0, sel, 4'hF});
      ring_req <= 1'b1;
      cnt(0, 1'b1, 40);
      `CHK(answer_line_out, 1'b1);
      `CHK(off_hook_out, 1'b1);
      wt(10);
      ring_req <= 1'b0;
      st(4'h2);
      `CHK(blind_out, 1'b0);
      wt(20);
      `CHK(ring_lamp, 1'b1);
      `CHK(term_ready_lamp, 1'b1);
   endtask : call

   task automatic conn(input int s);
      carrier_req <= 1'b1;
      cnt(1, 1'b1, 25000);
      `CHK(n inside {[TK * (dly[s] - 1) : TK * dly[s] + 14]}, 1'b1);
      wt(1);
      `CHK(answerback_store, 1'b0);
      `CHK(ring_lamp, 1'b0);
      `CHK(line_ready_lamp, 1'b1);
      `CHK(line_busy_out, 1'b0);
      st(4'h8);
   endtask : conn

   task automatic after_hang(input logic [3:0] cb);
      `CHK(blind_out, 1'b1);
      `CHK(line_busy_out, 1'b1);
      `CHK(off_hook_out, 1'b0);
      st(4'h1);
      apb(1'b0, ADDR_CAUSE, 32'h0);
      `CHK(rq[3:0], cb);
      apb(1'b1, ADDR_CAUSE, 32'h0000000F);
      apb(1'b0, ADDR_CAUSE, 32'h0);
      `CHK(rq[3:0], 4'h0);
      carrier_req <= 1'b0;
      space_req   <= 1'b0;
      wt(10);
   endtask : after_hang

   ////////////////////////////////////////////////////////////
   // Test sequence
   initial begin
      wt(2);
      arst_n <= 1'b1;
      wt(1);
      apb(1'b0, ADDR_CTRL, 32'h0);
      `CHK(rq, 32'h0000003E);
      st(4'h1);
      apb(1'b0, 8'h0C, 32'h0);
      `CHK({re, rq}, {1'b1, 32'h0});
      ring_req <= 1'b1;
      wt(20);
      `CHK(answer_line_out, 1'b0);
      `CHK(term_ready_lamp, 1'b0);
      ring_req <= 1'b0;
      wt(10);
      $display("test offline done");
      for (int s = 0; s < 9; s++) begin
         call(s[3:0]);
         conn(s);
         end_char_received <= 1'b1;
         @(posedge clk);
         end_char_received <= 1'b0;
         cnt(0, 1'b0, 5);
         `CHK(n <= 2, 1'b1);
         after_hang(4'h4);
      end
      $display("test delays done");
      call(4'h8);
      cnt(0, 1'b0, 21000);
      `CHK(n inside {[20400 : 20490]}, 1'b1);
      after_hang(4'h1);
      $display("test no carrier done");
      call(4'h8);
      conn(8);
      carrier_req <= 1'b0;
      wt(80);
      carrier_req <= 1'b1;
      wt(20);
      `CHK(line_ready_lamp, 1'b1);
      carrier_req <= 1'b0;
      cnt(0, 1'b0, 300);
      `CHK(n inside {[98 : 114]}, 1'b1);
      after_hang(4'h2);
      $display("test carrier loss done");
      call(4'h8);
      conn(8);
      space_req <= 1'b1;
      wt(2400);
      space_req <= 1'b0;
      wt(10);
      `CHK(line_ready_lamp, 1'b1);
      space_req <= 1'b1;
      cnt(0, 1'b0, 3000);
      `CHK(n inside {[TK * 1279 : TK * 1280 + 14]}, 1'b1);
      after_hang(4'h8);
      $display("test long space done");
      call(4'h8);
      conn(8);
      apb(1'b1, ADDR_CTRL, 32'h00000081);
      end_char_received <= 1'b1;
      @(posedge clk);
      end_char_received <= 1'b0;
      wt(5);
      `CHK(answer_line_out, 1'b1);
      space_req <= 1'b1;
      wt(2700);
      `CHK(line_ready_lamp, 1'b1);
      apb(1'b1, ADDR_CTRL, 32'h0);
      wt(2);
      `CHK(answer_line_out, 1'b0);
      `CHK(blind_out, 1'b0);
      `CHK(term_ready_lamp, 1'b0);
      space_req   <= 1'b0;
      carrier_req <= 1'b0;
      wt(10);
      $display("test options done");
      stop_test();
   end
endmodule : testbench
